/* fsip_defs.svh */
// Opcodes, register offsets, field positions, reset values and timing counts.
`ifndef FSIP_DEFS_SVH
`define FSIP_DEFS_SVH

`define FSIP_OP_IDENT_READ 8'h9F
`define FSIP_OP_STATUS_READ 8'h05
`define FSIP_OP_STATUS_WRITE 8'h01
`define FSIP_OP_WRITE_ENABLE 8'h06
`define FSIP_OP_WRITE_DISABLE 8'h04
`define FSIP_OP_PAGE_WRITE 8'h02
`define FSIP_OP_SECTOR_WIPE 8'hD8
`define FSIP_OP_BULK_ERASE 8'hC7

`define FSIP_TAG_LEN 8'h10
`define FSIP_CUSTOM_BLANK 8'h00
`define FSIP_IDENT_BYTES 5'd20

`define FSIP_SR_LOCK 7
`define FSIP_SR_BP_HI 4
`define FSIP_SR_BP_LO 2
`define FSIP_SR_LATCH 1
`define FSIP_SR_BUSY 0
`define FSIP_BP_RESET 3'h0
`define FSIP_LOCK_RESET 1'b0

`define FSIP_REG_CMD 8'h00
`define FSIP_REG_RXDATA 8'h04
`define FSIP_REG_STATE 8'h08
`define FSIP_REG_PIN 8'h0C
`define FSIP_CMD_OP_LSB 0
`define FSIP_CMD_DATA_LSB 8
`define FSIP_CMD_HAS_DATA 16
`define FSIP_CMD_RX_LSB 24
`define FSIP_PIN_RESET 1'b1

`define FSIP_CLK_NS 50
`define FSIP_T_STATUS_NS 5000
`define FSIP_T_PROGRAM_NS 20000
`define FSIP_T_ERASE_NS 100000
`define FSIP_T_SCLK_HALF_NS 400
`define FSIP_STATUS_CYC ((`FSIP_T_STATUS_NS + `FSIP_CLK_NS - 1) / `FSIP_CLK_NS)
`define FSIP_PROGRAM_CYC ((`FSIP_T_PROGRAM_NS + `FSIP_CLK_NS - 1) / `FSIP_CLK_NS)
`define FSIP_ERASE_CYC ((`FSIP_T_ERASE_NS + `FSIP_CLK_NS - 1) / `FSIP_CLK_NS)
`define FSIP_SCLK_HALF_CYC ((`FSIP_T_SCLK_HALF_NS + `FSIP_CLK_NS - 1) / `FSIP_CLK_NS)

`endif

/* fsip_pkg.sv */
// State types shared by both ends of the serial flash link.
`default_nettype none
package fsip_pkg;
	typedef enum logic [2:0] {ST_OPCODE, ST_ARGS, ST_PDATA, ST_DONE, ST_IDENT, ST_STATUS, ST_IGNORE} fsip_dev_state_e;
	typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} fsip_host_state_e;
endpackage
`default_nettype wire

/* fsip_if.sv */
// Serial link between the host controller and the flash status block.
`timescale 1ns/1ns
`default_nettype none
interface fsip_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic protect_pin;
	logic miso_out;
	logic miso_oe;
	logic miso_line;
	// The data line floats high through a pull-up while the device does not drive it.
	assign miso_line = miso_oe ? miso_out : 1'b1;
	modport dev (input sclk, input cs_n, input mosi, input protect_pin, output miso_out, output miso_oe);
	modport host (output sclk, output cs_n, output mosi, output protect_pin, input miso_line);
endinterface // fsip_if
`default_nettype wire

/* fsip_dev.sv */
// Flash end: identification readout, status byte, write latch and protection.
// How it works
// - Identify sends 3 id, length, 16 custom.
// - Length byte before custom data is 10h.
// - Custom data is read-only, default 00h.
// - Identify during busy cycle is not decoded.
// - Output bits change on serial clock falling.
// - Deselect ends readout, back to standby.
// - Status read always allowed, repeats while clocked.
// - Host polls busy flag before next opcode.
// - Busy flag set during any timed cycle.
// - Latch clear refuses writes, program, erase.
// - Protect bits guard regions against program, wipe.
// - Bulk erase only when protect bits zero.
// - Lock bit plus low pin blocks writes.
// - Status write needs latch, one data byte.
// - Bits 6,5,1,0 untouched; 6,5 read zero.
// - Extra bits after data byte discard write.
// - Deselect starts timed write; end clears latch.
// - Lock bit zero: writable with latch set.
// - Lock bit one: pin high allows write.
// - Lock mode follows later event; pin high exits.
// - Lock mode also freezes protected region.
// - Enable sets latch; disable, completions clear it.
// - Opcode byte first, most significant bit first.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "fsip_defs.svh"
module fsip_dev
	import fsip_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
	parameter logic [7:0] TYPE_CODE = 8'hA1, // Arbitrary value.
	parameter logic [7:0] SIZE_CODE = 8'h07, // Arbitrary value.
	parameter logic [127:0] CUSTOM_DATA = {16{`FSIP_CUSTOM_BLANK}}
)(
	input wire logic aclk,
	input wire logic aresetn,
	fsip_if.dev link,
	output logic [7:0] status_view,
	output logic hw_lock_mode
);

////////////////////////////////////////////////////////////////////////////////
logic [1:0] sclk_sy, cs_sy, mosi_sy, prot_sy;
logic sclk_q, cs_q;
logic rise, fall, selected, cs_rise, byte_done, lock_now, exec;
logic [7:0] in_byte, shift_in, opcode, wr_data, out_sr, status_now;
logic [2:0] bit_cnt, obit, sector, bp;
logic [1:0] arg_cnt;
logic [4:0] oidx;
logic [15:0] busy_cnt;
logic pdata_seen, busy, write_latch_flag, status_lock_bit, wr_pending;
fsip_dev_state_e state;

function automatic logic [1:0] arg_bytes(input logic [7:0] op);
	if (op == `FSIP_OP_STATUS_WRITE) arg_bytes = 2'd1;
	else if (op == `FSIP_OP_PAGE_WRITE || op == `FSIP_OP_SECTOR_WIPE) arg_bytes = 2'd3;
	else arg_bytes = 2'd0;
endfunction

function automatic logic [7:0] status_pack(input logic l, input logic [2:0] b, input logic w, input logic y);
	status_pack = {l, 2'b00, b, w, y};
endfunction

function automatic logic [7:0] ident_byte(input logic [4:0] idx);
	case (idx)
		5'd0: ident_byte = MAKER_CODE;
		5'd1: ident_byte = TYPE_CODE;
		5'd2: ident_byte = SIZE_CODE;
		5'd3: ident_byte = `FSIP_TAG_LEN;
		default: begin
			// Past the last custom byte the line reads zero.
			if (idx < `FSIP_IDENT_BYTES) ident_byte = CUSTOM_DATA[8 * (19 - int'(idx)) +: 8];
			else ident_byte = 8'h00;
		end
	endcase
endfunction

// Protected sectors grow from the top of the array as the field rises.
function automatic logic region_protected(input logic [2:0] b, input logic [2:0] s);
	case (b)
		3'd0: region_protected = 1'b0;
		3'd1: region_protected = (s == 3'd7);
		3'd2: region_protected = (s >= 3'd6);
		3'd3: region_protected = (s >= 3'd4);
		default: region_protected = 1'b1;
	endcase
endfunction

////////////////////////////////////////////////////////////////////////////////
// The serial clock is only sampled, so the link must run well below aclk.
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		sclk_sy <= 2'b00;
		cs_sy <= 2'b11;
		mosi_sy <= 2'b00;
		prot_sy <= 2'b11;
		sclk_q <= 1'b0;
		cs_q <= 1'b1;
	end else begin
		sclk_sy <= {sclk_sy[0], link.sclk};
		cs_sy <= {cs_sy[0], link.cs_n};
		mosi_sy <= {mosi_sy[0], link.mosi};
		prot_sy <= {prot_sy[0], link.protect_pin};
		sclk_q <= sclk_sy[1];
		cs_q <= cs_sy[1];
	end
end

assign selected = ~cs_sy[1];
assign rise = selected & sclk_sy[1] & ~sclk_q;
assign fall = selected & ~sclk_sy[1] & sclk_q;
assign cs_rise = cs_sy[1] & ~cs_q;
assign in_byte = {shift_in[6:0], mosi_sy[1]};
assign byte_done = rise & (bit_cnt == 3'd7);
assign lock_now = status_lock_bit & ~prot_sy[1];
assign status_now = status_pack(status_lock_bit, bp, write_latch_flag, busy);
assign exec = cs_rise & ((state == ST_DONE) | ((state == ST_PDATA) & pdata_seen & (bit_cnt == 3'd0)));

always_ff @(posedge aclk) begin
	if (!aresetn || !selected) begin
		bit_cnt <= 3'd0;
		shift_in <= 8'h00;
	end else if (rise) begin
		bit_cnt <= bit_cnt + 3'd1;
		shift_in <= in_byte;
	end
end

////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		state <= ST_OPCODE;
		opcode <= 8'h00;
		arg_cnt <= 2'd0;
		sector <= 3'd0;
		wr_data <= 8'h00;
		pdata_seen <= 1'b0;
	end else if (!selected) begin
		state <= ST_OPCODE;
	end else if (rise) begin
		case (state)
			ST_OPCODE: begin
				if (byte_done) begin
					opcode <= in_byte;
					arg_cnt <= 2'd0;
					pdata_seen <= 1'b0;
					case (in_byte)
						`FSIP_OP_STATUS_READ: state <= ST_STATUS;
						`FSIP_OP_IDENT_READ: state <= busy ? ST_IGNORE : ST_IDENT;
						`FSIP_OP_WRITE_ENABLE, `FSIP_OP_WRITE_DISABLE, `FSIP_OP_BULK_ERASE: begin
							state <= busy ? ST_IGNORE : ST_DONE;
						end
						`FSIP_OP_STATUS_WRITE, `FSIP_OP_PAGE_WRITE, `FSIP_OP_SECTOR_WIPE: begin
							state <= busy ? ST_IGNORE : ST_ARGS;
						end
						default: state <= ST_IGNORE;
					endcase
				end
			end
			ST_ARGS: begin
				if (byte_done) begin
					if (opcode == `FSIP_OP_STATUS_WRITE) wr_data <= in_byte;
					if (arg_cnt == 2'd0) sector <= in_byte[2:0];
					arg_cnt <= arg_cnt + 2'd1;
					if (2'(arg_cnt + 2'd1) == arg_bytes(opcode)) begin
						state <= (opcode == `FSIP_OP_PAGE_WRITE) ? ST_PDATA : ST_DONE;
					end
				end
			end
			ST_PDATA: begin
				if (byte_done) pdata_seen <= 1'b1;
			end
			ST_DONE: state <= ST_IGNORE;
			ST_IDENT, ST_STATUS, ST_IGNORE: state <= state;
			default: state <= ST_IGNORE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// The byte after the opcode is loaded at the eighth rising edge, then each
// falling edge puts one bit out.
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		link.miso_out <= 1'b0;
		link.miso_oe <= 1'b0;
		out_sr <= 8'h00;
		obit <= 3'd0;
		oidx <= 5'd0;
	end else if (!selected) begin
		link.miso_oe <= 1'b0;
		obit <= 3'd0;
	end else if (byte_done && state == ST_OPCODE) begin
		oidx <= 5'd1;
		obit <= 3'd0;
		out_sr <= (in_byte == `FSIP_OP_IDENT_READ) ? ident_byte(5'd0) : status_now;
	end else if (fall && (state == ST_IDENT || state == ST_STATUS)) begin
		link.miso_oe <= 1'b1;
		link.miso_out <= out_sr[7];
		obit <= obit + 3'd1;
		if (obit == 3'd7) begin
			out_sr <= (state == ST_IDENT) ? ident_byte(oidx) : status_now;
			oidx <= (oidx == 5'd31) ? oidx : oidx + 5'd1;
		end else begin
			out_sr <= {out_sr[6:0], 1'b0};
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// The protect and lock bits stand for non-volatile cells; reset returns them
// to their delivery state because this model has no real storage.
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		busy <= 1'b0;
		busy_cnt <= 16'h0000;
		write_latch_flag <= 1'b0;
		bp <= `FSIP_BP_RESET;
		status_lock_bit <= `FSIP_LOCK_RESET;
		wr_pending <= 1'b0;
	end else if (exec) begin
		case (opcode)
			`FSIP_OP_WRITE_ENABLE: write_latch_flag <= 1'b1;
			`FSIP_OP_WRITE_DISABLE: write_latch_flag <= 1'b0;
			`FSIP_OP_STATUS_WRITE: begin
				if (write_latch_flag && !lock_now) begin
					busy <= 1'b1;
					busy_cnt <= 16'(`FSIP_STATUS_CYC);
					wr_pending <= 1'b1;
				end
			end
			`FSIP_OP_PAGE_WRITE, `FSIP_OP_SECTOR_WIPE: begin
				if (write_latch_flag && !region_protected(bp, sector)) begin
					busy <= 1'b1;
					busy_cnt <= (opcode == `FSIP_OP_PAGE_WRITE) ? 16'(`FSIP_PROGRAM_CYC) : 16'(`FSIP_ERASE_CYC);
				end
			end
			`FSIP_OP_BULK_ERASE: begin
				if (write_latch_flag && bp == 3'd0) begin
					busy <= 1'b1;
					busy_cnt <= 16'(`FSIP_ERASE_CYC);
				end
			end
			default: busy <= busy;
		endcase
	end else if (busy) begin
		if (busy_cnt == 16'h0001) begin
			busy <= 1'b0;
			write_latch_flag <= 1'b0;
			wr_pending <= 1'b0;
			if (wr_pending) begin
				status_lock_bit <= wr_data[`FSIP_SR_LOCK];
				bp <= wr_data[`FSIP_SR_BP_HI:`FSIP_SR_BP_LO];
			end
		end else begin
			busy_cnt <= busy_cnt - 16'h0001;
		end
	end
end

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		status_view <= 8'h00;
		hw_lock_mode <= 1'b0;
	end else begin
		status_view <= status_now;
		hw_lock_mode <= lock_now;
	end
end

endmodule // fsip_dev
`default_nettype wire

/* fsip_host.sv */
// Host end: AXI4-Lite command registers driving the serial flash link.
`timescale 1ns/1ns
`default_nettype none
`include "fsip_defs.svh"
module fsip_host
	import fsip_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	fsip_if.host link
);

////////////////////////////////////////////////////////////////////////////////
logic [7:0] aw_addr;
logic [31:0] w_data, cmd_reg, rx_sr;
logic [3:0] w_strb;
logic do_write, start, aw_hit;
logic [1:0] miso_sy;
logic [3:0] div;
logic [8:0] nbit, total, tx_bits;
logic [15:0] tx_sr;
logic div_end;
fsip_host_state_e hst;

assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
assign aw_hit = (aw_addr == `FSIP_REG_CMD) || (aw_addr == `FSIP_REG_RXDATA) ||
	(aw_addr == `FSIP_REG_STATE) || (aw_addr == `FSIP_REG_PIN);
// A command written while a frame is still running is dropped; software polls first.
assign start = do_write & (aw_addr == `FSIP_REG_CMD) & w_strb[0] & (hst == H_IDLE);
assign div_end = (div == 4'(`FSIP_SCLK_HALF_CYC - 1));

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'b00;
		aw_addr <= 8'h00;
		w_data <= 32'h0000_0000;
		w_strb <= 4'h0;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= aw_hit ? 2'b00 : 2'b10;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		cmd_reg <= 32'h0000_0000;
		link.protect_pin <= `FSIP_PIN_RESET;
	end else if (do_write) begin
		if (start) cmd_reg <= w_data;
		if (aw_addr == `FSIP_REG_PIN && w_strb[0]) link.protect_pin <= w_data[0];
	end
end

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= 2'b00;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= 2'b00;
		case (s_axi_araddr)
			`FSIP_REG_CMD: s_axi_rdata <= cmd_reg;
			`FSIP_REG_RXDATA: s_axi_rdata <= rx_sr;
			`FSIP_REG_STATE: s_axi_rdata <= {31'h0, hst != H_IDLE};
			`FSIP_REG_PIN: s_axi_rdata <= {31'h0, link.protect_pin};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'b10;
			end
		endcase
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
		s_axi_arready <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// The half period leaves room for both synchronisers and the flash output flop
// between a falling edge and the host's sample at the next rising edge.
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		miso_sy <= 2'b11;
	end else begin
		miso_sy <= {miso_sy[0], link.miso_line};
	end
end

always_ff @(posedge aclk) begin
	if (!aresetn) begin
		hst <= H_IDLE;
		link.sclk <= 1'b0;
		link.cs_n <= 1'b1;
		link.mosi <= 1'b0;
		div <= 4'd0;
		nbit <= 9'd0;
		total <= 9'd0;
		tx_bits <= 9'd0;
		tx_sr <= 16'h0000;
		rx_sr <= 32'h0000_0000;
	end else begin
		div <= (hst == H_IDLE || div_end) ? 4'd0 : div + 4'd1;
		case (hst)
			H_IDLE: begin
				if (start) begin
					// Frames are whole bytes, so the select always rises on a boundary.
					tx_bits <= w_data[`FSIP_CMD_HAS_DATA] ? 9'd16 : 9'd8;
					total <= (w_data[`FSIP_CMD_HAS_DATA] ? 9'd16 : 9'd8) +
						{1'b0, w_data[`FSIP_CMD_RX_LSB +: 5], 3'b000};
					tx_sr <= {w_data[`FSIP_CMD_OP_LSB +: 8], w_data[`FSIP_CMD_DATA_LSB +: 8]};
					link.mosi <= w_data[`FSIP_CMD_OP_LSB + 7];
					link.cs_n <= 1'b0;
					nbit <= 9'd0;
					hst <= H_LOW;
				end
			end
			H_LOW: begin
				if (div_end) begin
					link.sclk <= 1'b1;
					if (nbit >= tx_bits) rx_sr <= {rx_sr[30:0], miso_sy[1]};
					hst <= H_HIGH;
				end
			end
			H_HIGH: begin
				if (div_end) begin
					link.sclk <= 1'b0;
					nbit <= nbit + 9'd1;
					if (9'(nbit + 9'd1) == total) begin
						hst <= H_TAIL;
					end else begin
						link.mosi <= tx_sr[14];
						tx_sr <= {tx_sr[14:0], 1'b0};
						hst <= H_LOW;
					end
				end
			end
			H_TAIL: begin
				if (div_end) begin
					link.cs_n <= 1'b1;
					link.mosi <= 1'b0;
					hst <= H_GAP;
				end
			end
			H_GAP: begin
				if (div_end) hst <= H_IDLE;
			end
			default: hst <= H_IDLE;
		endcase
	end
end

endmodule // fsip_host
`default_nettype wire

/* fsip_props.sv */
// Concurrent checks on the serial link and the flash end's status outputs.
`timescale 1ns/1ns
`default_nettype none
module fsip_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic protect_pin,
	input wire logic miso_out,
	input wire logic miso_oe,
	input wire logic miso_line,
	input wire logic [7:0] status_view,
	input wire logic hw_lock_mode
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// Busy length is judged only when it ends, so one counter serves all three cycle kinds.
	logic [11:0] busy_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn || !status_view[0]) begin
			busy_cnt <= 12'h000;
		end else begin
			busy_cnt <= busy_cnt + 12'h001;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_release_oe: assert property ($rose(cs_n) |-> ##[0:3] !miso_oe)
		else $error("data line still driven after deselect");
	a_fall_launch: assert property ((!cs_n && miso_oe && $changed(miso_out)) |-> !sclk)
		else $error("output bit changed while serial clock high");
	a_zero_bits: assert property (status_view[6:5] == 2'h0)
		else $error("status bits 6 and 5 not zero");
	a_busy_length: assert property ($fell(status_view[0]) |->
		busy_cnt inside {[99:101], [399:401], [1999:2001]})
		else $error("self-timed cycle of wrong length");
	a_end_clears: assert property ($fell(status_view[0]) |-> !status_view[1])
		else $error("latch still set after timed cycle");
	a_busy_start: assert property ($rose(status_view[0]) |-> cs_n && status_view[1])
		else $error("timed cycle began without latch or while selected");
	a_latch_set: assert property ($rose(status_view[1]) |-> cs_n && !status_view[0])
		else $error("latch set outside a completed enable");
	a_nv_change: assert property ($changed(status_view[7:2]) |-> $fell(status_view[0]))
		else $error("protect or lock bits changed outside a status write end");
	a_lock_enter: assert property ((status_view[7] && !protect_pin)[*5] |-> hw_lock_mode)
		else $error("lock mode not entered");
	a_lock_exit: assert property (protect_pin[*5] |-> !hw_lock_mode)
		else $error("lock mode not left with pin high");
	a_lock_freeze: assert property (hw_lock_mode |=> $stable(status_view[7:2]))
		else $error("protect bits changed in lock mode");
	a_mosi_hold: assert property ((!cs_n && sclk) |-> $stable(mosi))
		else $error("host data changed while serial clock high");
	a_idle_line: assert property (cs_n[*4] |-> (!miso_oe && miso_line))
		else $error("data line not released while deselected");
endmodule // fsip_props
`default_nettype wire

/* fsip_tb.sv */
// Self-checking bench: host and flash ends joined over the serial link.
`timescale 1ns/1ns
`default_nettype none
`include "fsip_defs.svh"
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
	$display("Error %s expected %h seen %h", what, exp, got); end end
module fsip_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, hw_lock_mode;
	logic [1:0] bresp, rresp, last_resp;
	logic [31:0] rdata, rd;
	logic [7:0] status_view;
	int fail_count = 0;
	int comparisons = 0;
	localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value.
	localparam logic [7:0] KIND = 8'hC3; // Arbitrary value.
	localparam logic [7:0] SIZE = 8'h5E; // Arbitrary value.
	// A non-blank pattern shows byte order, which all-zero content would hide.
	localparam logic [127:0] CUSTOM = 128'h0102_0304_0506_0708_090A_0B0C_0D0E_0F10;
	////////////////////////////////////////////////////////////////////////////////
	fsip_if link();
	fsip_host u_fsip_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
	fsip_dev #(.MAKER_CODE(MAKER), .TYPE_CODE(KIND), .SIZE_CODE(SIZE), .CUSTOM_DATA(CUSTOM)) u_fsip_dev (
		.aclk(aclk), .aresetn(aresetn), .link(link), .status_view(status_view), .hw_lock_mode(hw_lock_mode));
	fsip_props u_fsip_props (.aclk(aclk), .aresetn(aresetn), .sclk(link.sclk), .cs_n(link.cs_n),
		.mosi(link.mosi), .protect_pin(link.protect_pin), .miso_out(link.miso_out), .miso_oe(link.miso_oe),
		.miso_line(link.miso_line), .status_view(status_view), .hw_lock_mode(hw_lock_mode));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic hung();
		fail_count++;
		$display("Error handshake wait expected done seen timeout");
		wrap_up();
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		if (n == 100) hung();
		@(posedge aclk);
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		last_resp = rresp;
		rready <= 1'b0;
		if (n == 100) hung();
		@(posedge aclk);
	endtask
	// Sends one frame and waits for the host to finish it, then fetches the received bits.
	task automatic link_cmd(input logic [7:0] op, input logic [7:0] d, input logic has, input logic [4:0] cnt);
		int n;
		axi_write(`FSIP_REG_CMD, {3'h0, cnt, 7'h00, has, d, op});
		for (n = 0; n < 3000; n++) begin
			axi_read(`FSIP_REG_STATE, rd);
			if (rd[0] === 1'b0) break;
		end
		if (n == 3000) hung();
		axi_read(`FSIP_REG_RXDATA, rd);
	endtask
	task automatic expect_status(input logic [7:0] e);
		link_cmd(`FSIP_OP_STATUS_READ, 8'h00, 1'b0, 5'h01);
		`CHECK("status byte", e, rd[7:0])
		`CHECK("status view", e, status_view)
	endtask
	// Polls the busy flag over the link, as software would between write operations.
	task automatic wait_ready();
		int n;
		for (n = 0; n < 50; n++) begin
			link_cmd(`FSIP_OP_STATUS_READ, 8'h00, 1'b0, 5'h01);
			if (rd[0] === 1'b0) break;
		end
		if (n == 50) hung();
	endtask
	task automatic write_status(input logic [7:0] v);
		link_cmd(`FSIP_OP_WRITE_ENABLE, 8'h00, 1'b0, 5'h00);
		link_cmd(`FSIP_OP_STATUS_WRITE, v, 1'b1, 5'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHECK("reset status", 8'h00, status_view)
		`CHECK("reset lock mode", 1'b0, hw_lock_mode)
		axi_read(`FSIP_REG_PIN, rd);
		`CHECK("pin reset", 32'h0000_0001, rd)
		axi_read(8'h10, rd);
		`CHECK("unmapped response", 2'h2, last_resp)
		link_cmd(`FSIP_OP_IDENT_READ, 8'h00, 1'b0, 5'h04);
		`CHECK("ident head", {MAKER, KIND, SIZE, `FSIP_TAG_LEN}, rd)
		link_cmd(`FSIP_OP_IDENT_READ, 8'h00, 1'b0, 5'h08);
		`CHECK("custom start", CUSTOM[127:96], rd)
		link_cmd(`FSIP_OP_IDENT_READ, 8'h00, 1'b0, 5'h15);
		`CHECK("custom end", {CUSTOM[23:0], 8'h00}, rd)
		link_cmd(`FSIP_OP_STATUS_WRITE, 8'h9C, 1'b1, 5'h00);
		expect_status(8'h00);
		link_cmd(`FSIP_OP_WRITE_ENABLE, 8'h00, 1'b0, 5'h00);
		expect_status(8'h02);
		link_cmd(`FSIP_OP_WRITE_DISABLE, 8'h00, 1'b0, 5'h00);
		expect_status(8'h00);
		write_status(8'hFF);
		`CHECK("busy during write", 1'b1, status_view[0])
		wait_ready();
		expect_status(8'h9C);
		link_cmd(`FSIP_OP_WRITE_ENABLE, 8'h00, 1'b0, 5'h00);
		link_cmd(`FSIP_OP_BULK_ERASE, 8'h00, 1'b0, 5'h00);
		expect_status(8'h9E);
		axi_write(`FSIP_REG_PIN, 32'h0000_0000);
		link_cmd(`FSIP_OP_STATUS_WRITE, 8'h00, 1'b1, 5'h00);
		expect_status(8'h9E);
		`CHECK("lock mode on", 1'b1, hw_lock_mode)
		axi_write(`FSIP_REG_PIN, 32'h0000_0001);
		link_cmd(`FSIP_OP_STATUS_WRITE, 8'h00, 1'b1, 5'h00);
		wait_ready();
		expect_status(8'h00);
		`CHECK("lock mode off", 1'b0, hw_lock_mode)
		axi_write(`FSIP_REG_PIN, 32'h0000_0000);
		write_status(8'h80);
		wait_ready();
		expect_status(8'h80);
		`CHECK("lock mode late", 1'b1, hw_lock_mode)
		axi_write(`FSIP_REG_PIN, 32'h0000_0001);
		write_status(8'h00);
		wait_ready();
		link_cmd(`FSIP_OP_WRITE_ENABLE, 8'h00, 1'b0, 5'h00);
		link_cmd(`FSIP_OP_STATUS_WRITE, 8'h1C, 1'b1, 5'h01);
		expect_status(8'h02);
		link_cmd(`FSIP_OP_BULK_ERASE, 8'h00, 1'b0, 5'h00);
		link_cmd(`FSIP_OP_STATUS_READ, 8'h00, 1'b0, 5'h03);
		`CHECK("status while busy", 24'h03_0303, rd[23:0])
		link_cmd(`FSIP_OP_IDENT_READ, 8'h00, 1'b0, 5'h04);
		`CHECK("ident while busy", 32'hFFFF_FFFF, rd)
		link_cmd(`FSIP_OP_STATUS_READ, 8'h00, 1'b0, 5'h1F);
		`CHECK("live status", 32'h0000_0000, rd)
		write_status(8'h04);
		wait_ready();
		link_cmd(`FSIP_OP_WRITE_ENABLE, 8'h00, 1'b0, 5'h00);
		link_cmd(`FSIP_OP_SECTOR_WIPE, 8'h07, 1'b1, 5'h02);
		expect_status(8'h06);
		link_cmd(`FSIP_OP_SECTOR_WIPE, 8'h00, 1'b1, 5'h02);
		`CHECK("wipe busy", 1'b1, status_view[0])
		wait_ready();
		expect_status(8'h04);
		link_cmd(`FSIP_OP_WRITE_ENABLE, 8'h00, 1'b0, 5'h00);
		link_cmd(`FSIP_OP_PAGE_WRITE, 8'h00, 1'b1, 5'h03);
		`CHECK("program busy", 1'b1, status_view[0])
		wait_ready();
		expect_status(8'h04);
		wrap_up();
	end
endmodule // fsip_tb
`default_nettype wire
